// ### ept_pkg.sv
// Purpose: Shared constants for the energy pulse output timing block.
// Assumes: Master clock of 10 MHz on i_clk_sys.
// Notes: Times are kept in their own units; cycle counts derive from them.
package ept_pkg;
  // ***********************************************************************
  // Clock and time figures
  // ***********************************************************************
  localparam int CLK_HZ = 10_000_000;
  localparam int F_HIGH_MS = 275;
  localparam int CF_HIGH_MS = 90;
  localparam int CF_HF_US = 1;
  localparam int SEP_CLKS = 4;
  // Derived cycle counts
  localparam int F_HIGH_CYC = F_HIGH_MS * (CLK_HZ / 1000);
  localparam int CF_HIGH_CYC = CF_HIGH_MS * (CLK_HZ / 1000);
  localparam int CF_HF_CYC = CF_HF_US * (CLK_HZ / 1_000_000);
  // ***********************************************************************
  // Datapath shape and reset values
  // ***********************************************************************
  localparam int HPF_SHIFT = 8;
  localparam int CNT_W = 32;
  localparam int ACC_W = 48;
  localparam logic [31:0] CNT_RST = 32'h0000_0000;
  localparam logic [47:0] ACC_RST = 48'h0000_0000_0000;
  localparam logic [31:0] SAT_MAX = 32'hFFFF_FFFF;
endpackage

// ### ept_hpf.sv
// Purpose: First-order high-pass filter that strips offset from current.
// Assumes: Samples arrive with a one-cycle valid on the system clock.
// Notes: Corner set by the shift; larger shift means a lower corner.
`timescale 1ns/1ps
module ept_hpf #(
  parameter int DW = 16,
  parameter int SHIFT = ept_pkg::HPF_SHIFT
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Sample in
  input wire logic i_valid,
  input wire logic signed [DW-1:0] i_x,
  // Filtered sample out
  output logic o_valid,
  output logic signed [DW-1:0] o_y
);
  logic signed [DW+SHIFT-1:0] dc_acc;
  logic signed [DW-1:0] dc_est;
  logic signed [DW-1:0] next_y;

  // Offset estimate and its removal
  assign dc_est = DW'(dc_acc >>> SHIFT);
  assign next_y = DW'(i_x - dc_est);

  // Running offset tracks the low-frequency part of the input
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      dc_acc <= '0;
    end else if (i_valid) begin
      dc_acc <= (DW+SHIFT)'(dc_acc + next_y);
    end
  end

  // Registered output so the product stage sees a clean word
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_valid <= 1'b0;
      o_y <= '0;
    end else begin
      o_valid <= i_valid;
      if (i_valid) begin
        o_y <= next_y;
      end
    end
  end
endmodule

// ### ept_pulse_out.sv
// Purpose: Energy-to-pulse conversion and pulse shaping for the outputs.
// Assumes: Voltage, current and phase signs come from same-clock logic.
// Notes: Widths shrink with rate, except calibration in high-frequency mode; overlap guard relies on steady rate.
`timescale 1ns/1ps
module ept_pulse_out #(
  parameter int DW = 16,
  parameter int F_HIGH_CYC = ept_pkg::F_HIGH_CYC,
  parameter int CF_HIGH_CYC = ept_pkg::CF_HIGH_CYC,
  parameter logic [47:0] CF_THRESH = 48'h0000_0100_0000,
  parameter logic [47:0] F_THRESH = 48'h0000_1000_0000
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Measurement samples
  input wire logic i_sample_valid,
  input wire logic signed [DW-1:0] i_voltage,
  input wire logic signed [DW-1:0] i_current,
  input wire logic [2:0] i_phase_negative,
  // Mode
  input wire logic i_hf_mode,
  // Pulse outputs
  output logic o_energy_pulse_a,
  output logic o_energy_pulse_b,
  output logic o_calibration_pulse,
  output logic o_reverse_power_flag
);
  localparam int PW = 2 * DW;
  localparam int AW = ept_pkg::ACC_W;
  localparam int CW = ept_pkg::CNT_W;

  // ***********************************************************************
  // Current offset removal and power product
  // ***********************************************************************
  logic hp_valid;
  logic signed [DW-1:0] hp_current;
  logic signed [DW-1:0] volt_q;
  logic prod_valid;
  logic signed [PW-1:0] power;
  logic [PW-1:0] power_mag;

  ept_hpf #(
    .DW(DW),
    .SHIFT(ept_pkg::HPF_SHIFT)
  ) u_hpf (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_valid(i_sample_valid),
    .i_x(i_current),
    .o_valid(hp_valid),
    .o_y(hp_current)
  );

  // Voltage delayed to line up with the filtered current
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      volt_q <= '0;
    end else if (i_sample_valid) begin
      volt_q <= i_voltage;
    end
  end

  // Instantaneous power
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      prod_valid <= 1'b0;
      power <= '0;
    end else begin
      prod_valid <= hp_valid;
      if (hp_valid) begin
        power <= volt_q * hp_current;
      end
    end
  end

  // Magnitude; the sign is carried separately by the phase flags
  assign power_mag = power[PW-1] ? PW'(-power) : PW'(power);

  // ***********************************************************************
  // Energy accumulation
  // ***********************************************************************
  logic [AW-1:0] acc_cf;
  logic [AW-1:0] acc_f;
  logic [AW-1:0] sum_cf;
  logic [AW-1:0] sum_f;
  logic fire_cf;
  logic fire_f;

  assign sum_cf = acc_cf + AW'(power_mag);
  assign sum_f = acc_f + AW'(power_mag);
  assign fire_cf = prod_valid && (sum_cf >= CF_THRESH);
  assign fire_f = prod_valid && (sum_f >= F_THRESH);

  // Remainder kept on each crossing so no energy is dropped
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      acc_cf <= ept_pkg::ACC_RST;
      acc_f <= ept_pkg::ACC_RST;
    end else if (prod_valid) begin
      acc_cf <= fire_cf ? AW'(sum_cf - CF_THRESH) : sum_cf;
      acc_f <= fire_f ? AW'(sum_f - F_THRESH) : sum_f;
    end
  end

  // ***********************************************************************
  // Period measurement and width choice
  // ***********************************************************************
  logic [CW-1:0] since_cf;
  logic [CW-1:0] since_f;
  logic sel_b;
  logic [CW-1:0] half_cf;
  logic [CW-1:0] room_f;
  logic [CW-1:0] width_cf;
  logic [CW-1:0] width_f;

  logic energy_seen;
  logic timing_on;

  // Timers wait for the first product, so pipeline idle time after
  // reset cannot widen the first pulse past the next crossing
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      energy_seen <= 1'b0;
    end else if (prod_valid) begin
      energy_seen <= 1'b1;
    end
  end

  assign timing_on = energy_seen | prod_valid;

  // Cycles since last crossing, saturating so slow rates stay sane
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      since_cf <= ept_pkg::CNT_RST;
      since_f <= ept_pkg::CNT_RST;
    end else begin
      if (fire_cf) begin
        since_cf <= CW'(1);
      end else if (timing_on && since_cf != ept_pkg::SAT_MAX) begin
        since_cf <= since_cf + CW'(1);
      end
      if (fire_f) begin
        since_f <= CW'(1);
      end else if (timing_on && since_f != ept_pkg::SAT_MAX) begin
        since_f <= since_f + CW'(1);
      end
    end
  end

  // Alternate crossings so b falls half an output period after a
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      sel_b <= 1'b0;
    end else if (fire_f) begin
      sel_b <= ~sel_b;
    end
  end

  // Shrink widths at high rate; never below one cycle
  // One spare cycle: kept remainders let intervals differ by one
  always_comb begin
    half_cf = since_cf >> 1;
    if (since_f > CW'(ept_pkg::SEP_CLKS + 1)) begin
      room_f = since_f - CW'(ept_pkg::SEP_CLKS + 1);
    end else begin
      room_f = CW'(1);
    end
    if (i_hf_mode) begin
      width_cf = CW'(ept_pkg::CF_HF_CYC);
    end else if (half_cf < CW'(CF_HIGH_CYC)) begin
      width_cf = (half_cf == '0) ? CW'(1) : half_cf;
    end else begin
      width_cf = CW'(CF_HIGH_CYC);
    end
    if (room_f < CW'(F_HIGH_CYC)) begin
      width_f = room_f;
    end else begin
      width_f = CW'(F_HIGH_CYC);
    end
  end

  // ***********************************************************************
  // Pulse generators: 0 = a, 1 = b, 2 = calibration
  // ***********************************************************************
  logic [2:0] fire;
  logic [CW-1:0] width [3];
  logic [CW-1:0] cnt [3];
  logic [CW-1:0] wid_q [3];
  logic [CW-1:0] hi_len [3];
  logic [2:0] pulse;

  assign fire = {fire_cf, fire_f & sel_b, fire_f & ~sel_b};
  assign width[0] = width_f;
  assign width[1] = width_f;
  assign width[2] = width_cf;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_pulse
      // High for exactly the loaded number of cycles
      always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
          cnt[g] <= ept_pkg::CNT_RST;
          wid_q[g] <= ept_pkg::CNT_RST;
          pulse[g] <= 1'b0;
        end else begin
          if (fire[g]) begin
            cnt[g] <= width[g];
            wid_q[g] <= width[g];
          end else if (cnt[g] != '0) begin
            cnt[g] <= cnt[g] - CW'(1);
          end
          pulse[g] <= fire[g] || (cnt[g] > CW'(1));
        end
      end
      // High-time meter read only by the checks
      always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
          hi_len[g] <= ept_pkg::CNT_RST;
        end else begin
          hi_len[g] <= pulse[g] ? hi_len[g] + CW'(1) : CW'(0);
        end
      end
    end
  endgenerate

  assign o_energy_pulse_a = pulse[0];
  assign o_energy_pulse_b = pulse[1];
  assign o_calibration_pulse = pulse[2];

  // Reverse flag moves only together with a calibration pulse
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_reverse_power_flag <= 1'b0;
    end else if (fire_cf) begin
      o_reverse_power_flag <= |i_phase_negative;
    end
  end

  // ***********************************************************************
  // Checks
  // ***********************************************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  a_width_fixed_a: assert property (
    $fell(pulse[0]) |-> hi_len[0] == wid_q[0] && wid_q[0] <= F_HIGH_CYC)
    else $error("energy pulse a width wrong");
  b_stagger_a: assert property (
    fire_f |=> sel_b != $past(sel_b) && (pulse[0] ^ $past(sel_b)))
    else $error("energy outputs do not alternate");
  cf_width_a: assert property (
    $fell(pulse[2]) |-> hi_len[2] == wid_q[2] && wid_q[2] <= CF_HIGH_CYC)
    else $error("calibration width wrong");
  cf_hf_pulse_a: assert property (
    fire_cf && i_hf_mode ##1 !fire_cf [*8] ##1 !fire_cf ##1 !fire_cf |->
      pulse[2] && hi_len[2] == ept_pkg::CF_HF_CYC - 1 ##1 !pulse[2])
    else $error("calibration pulse not 1 us in fast mode");
  cf_shrink_a: assert property (
    fire_cf && !i_hf_mode |=>
      wid_q[2] == 1 || wid_q[2] <= ($past(since_cf) >> 1))
    else $error("calibration width exceeds half period");
  f_gap_a: assert property (
    fire_f && since_f > ept_pkg::SEP_CLKS + 1 |=>
      wid_q[$past(sel_b)] + ept_pkg::SEP_CLKS < $past(since_f))
    else $error("energy pulse gap too short");
  hpf_path_a: assert property (
    i_sample_valid |=> hp_valid ##1 prod_valid)
    else $error("current sample bypassed the filter");
  rev_flag_a: assert property (
    fire_cf |=> o_reverse_power_flag == $past(|i_phase_negative))
    else $error("reverse flag not updated with calibration pulse");
  rev_hold_a: assert property (
    !fire_cf |=> $stable(o_reverse_power_flag))
    else $error("reverse flag moved between calibration pulses");
  energy_cross_a: assert property (
    prod_valid && sum_cf < CF_THRESH |-> !fire_cf ##1 pulse[2] == 1'b0
      || $past(cnt[2]) > 1)
    else $error("calibration pulse without enough energy");
endmodule

// ### ept_meter.sv
// Purpose: Far-side counter model that measures each pulse high time.
// Assumes: The pulse is registered on the same clock as the meter.
// Notes: Reports once per pulse, the cycle after its falling edge.
`timescale 1ns/1ps
module ept_meter (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Pulse watched
  input wire logic i_pulse,
  // Measurement
  output logic o_done,
  output logic [31:0] o_width
);
  logic [31:0] cnt;
  // Count high cycles; a coil only responds to the level
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      cnt <= 32'h0000_0000;
      o_done <= 1'b0;
      o_width <= 32'h0000_0000;
    end else begin
      o_done <= 1'b0;
      if (i_pulse) begin
        cnt <= cnt + 32'h0000_0001;
      end else if (cnt != 32'h0000_0000) begin
        o_done <= 1'b1;
        o_width <= cnt;
        cnt <= 32'h0000_0000;
      end
    end
  end
endmodule

// ### ept_pulse_out_bench.sv
// Purpose: Self-checking bench for the energy pulse output block.
// Assumes: Short widths and small thresholds keep the run brief.
// Notes: First pulse after a reset has no known interval; not judged, except calibration in high-frequency mode.
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch at %0t got %h expected %h", $time, g, e); end end
module ept_pulse_out_bench;
  localparam int FW = 50;
  localparam int CW = 20;
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_sample_valid = 1'b0;
  logic [15:0] i_voltage = 16'h0000;
  logic [15:0] i_current = 16'h0000;
  logic [2:0] i_phase_negative = 3'h0;
  logic i_hf_mode = 1'b0;
  logic pa, pb, pc, rf, da, db, dc;
  logic [31:0] wa, wb, wc;
  int n_mismatch = 0;
  int checked = 0;
  logic [15:0] lf = 16'hA330; // Seed 41776
  logic [33:0] q_ab[$];
  logic [33:0] q_cf[$];
  logic [33:0] n;
  int cyc = 0, t_ab = 0, t_cf = 0, t_fall = 0, n_ab = 0, w = 0;
  logic hab = 0, hcf = 0, lb = 1, ppa = 0, ppb = 0, ppc = 0, prf = 0;
  logic prst = 1'b1;
  logic [2:0] ppn = 3'h0;
  // ***********************************************************************
  // Design and far-side models
  // ***********************************************************************
  ept_pulse_out #(.DW(16), .F_HIGH_CYC(FW), .CF_HIGH_CYC(CW),
    .CF_THRESH(48'h0000_0010_0000), .F_THRESH(48'h0000_0020_0000)) dut (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_sample_valid(i_sample_valid), .i_voltage(i_voltage),
    .i_current(i_current), .i_phase_negative(i_phase_negative),
    .i_hf_mode(i_hf_mode), .o_energy_pulse_a(pa), .o_energy_pulse_b(pb),
    .o_calibration_pulse(pc), .o_reverse_power_flag(rf));
  ept_meter m_a (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_pulse(pa),
    .o_done(da), .o_width(wa));
  ept_meter m_b (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_pulse(pb),
    .o_done(db), .o_width(wb));
  ept_meter m_c (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_pulse(pc),
    .o_done(dc), .o_width(wc));
  // ***********************************************************************
  // Clock, stimulus and checks
  // ***********************************************************************
  always #50 i_clk_sys = ~i_clk_sys;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic stop_test();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Alternating signs keep power positive and pass the offset filter
  task automatic run_phase(input string nm, input logic [15:0] amp,
    input logic hf, input int cycles);
    logic sg;
    sg = 1'b0;
    n_ab = 0;
    i_hf_mode <= hf;
    repeat (cycles) begin
      @(posedge i_clk_sys);
      lf = lfsr(lf);
      sg = ~sg;
      i_sample_valid <= 1'b1;
      i_voltage <= sg ? amp : 16'h0000 - amp;
      i_current <= sg ? amp : 16'h0000 - amp;
      if (lf[5:0] == 6'h00) i_phase_negative <= lf[15:13];
    end
    `CHK(n_ab > 2, 1'b1)
    // Reset while pulses run: outputs must drop at the first clock edge in reset
    i_rst_n <= 1'b0;
    i_sample_valid <= 1'b0;
    repeat (5) @(posedge i_clk_sys);
    q_ab.delete();
    q_cf.delete();
    i_rst_n <= 1'b1;
    $display("test %s done", nm);
  endtask
  // Monitor notes expected widths at rises, judges them at reports
  always @(negedge i_clk_sys) begin
    cyc++;
    if (!i_rst_n) begin
      // Judged only once an edge has taken the reset
      if (!prst) `CHK({pa, pb, pc, rf}, 4'h0)
      hab = 1'b0;
      hcf = 1'b0;
      lb = 1'b1;
    end else begin
      if (rf !== prf) `CHK(pc && !ppc, 1'b1)
      if ((!pa && ppa) || (!pb && ppb)) t_fall = cyc;
      if ((pa && !ppa) || (pb && !ppb)) begin
        w = cyc - t_ab - 5; // Gap plus one cycle of crossing jitter
        w = (w > FW) ? FW : ((w < 1) ? 1 : w);
        q_ab.push_back({hab, pb, w[31:0]});
        `CHK(pb, ~lb)
        if (hab) `CHK(cyc - t_fall >= 4, 1'b1)
        lb = pb;
        t_ab = cyc;
        hab = 1'b1;
        n_ab++;
      end
      if (pc && !ppc) begin
        w = (cyc - t_cf) / 2;
        w = (w > CW) ? CW : ((w < 1) ? 1 : w);
        if (i_hf_mode) w = ept_pkg::CF_HF_CYC;
        q_cf.push_back({hcf | i_hf_mode, 1'b0, w[31:0]});
        `CHK(rf, |ppn)
        t_cf = cyc;
        hcf = 1'b1;
      end
      if (da || db) begin
        n = (q_ab.size() > 0) ? q_ab.pop_front() : 34'h2_0000_0000;
        if (n[33]) `CHK(db, n[32])
        if (n[33]) `CHK(da ? wa : wb, n[31:0])
      end
      if (dc) begin
        n = (q_cf.size() > 0) ? q_cf.pop_front() : 34'h2_0000_0000;
        if (n[33]) `CHK(wc, n[31:0])
      end
    end
    {ppa, ppb, ppc, prf, ppn, prst} = {pa, pb, pc, rf, i_phase_negative,
      i_rst_n};
  end
  // Main sequence: slow rate, fast rate, then high-frequency mode
  initial begin
    repeat (5) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    run_phase("slow", 16'h0040, 1'b0, 2000);
    run_phase("fast", 16'h0100, 1'b0, 600);
    run_phase("high_freq", 16'h0080, 1'b1, 800);
    stop_test();
  end
  // Watchdog: about three times the expected run length
  initial begin
    #1000000;
    n_mismatch++;
    stop_test();
  end
endmodule
